/* rvm_pkg.sv */
package rvm_pkg;

	localparam logic [8:0] ADDR_CONTROL    = 9'h114;
	localparam logic [8:0] ADDR_ENABLE_LA  = 9'h115;
	localparam logic [8:0] ADDR_ENABLE_LB  = 9'h116;
	localparam logic [8:0] ADDR_ENABLE_BK  = 9'h117;
	localparam logic [8:0] ADDR_LAST_89    = 9'h11E;
	localparam logic [8:0] ADDR_LAST_10    = 9'h11F;

	localparam logic [7:0] RST_CONTROL     = 8'h00;
	localparam logic [7:0] RST_ENABLE_LA   = 8'h00;
	localparam logic [7:0] RST_ENABLE_LB   = 8'h00;
	localparam logic [7:0] RST_ENABLE_BK   = 8'h00;

	// Writable bits of each enable register; reserved bits read back zero.
	localparam logic [7:0] MASK_ENABLE_LA  = 8'hC4;
	localparam logic [7:0] MASK_ENABLE_LB  = 8'h05;
	localparam logic [7:0] MASK_ENABLE_BK  = 8'hFC;

	localparam int CTL_DELAY_LSB   = 6;
	localparam int CTL_MODE_LSB    = 4;
	localparam int CTL_DEBOUNCE    = 3;
	localparam int CTL_RESET_EN    = 2;
	localparam int CTL_THRES_LSB   = 0;
	localparam int LAST9_LSB       = 4;
	localparam int LAST8_LSB       = 0;
	localparam int LAST10_LSB      = 0;

	// Shift that turns a target into its deviation limit: 25 % is a shift of two.
	localparam logic [3:0] THRES_BASE_SHIFT = 4'h2;

	localparam int NUM_REG = 11;
	localparam int NUM_CH  = 3;

	typedef enum logic [1:0] {
		RVM_MODE_LOCKOUT = 2'b00,
		RVM_MODE_NORMAL  = 2'b01,
		RVM_MODE_BURST   = 2'b10,
		RVM_MODE_RSVD    = 2'b11
	} rvm_mode_e;

	// One finished auto measurement from the converter on one monitor channel.
	typedef struct packed {
		logic       done;
		logic       fresh;
		logic [2:0] index;
		logic [7:0] value;
		logic [7:0] target;
	} rvm_meas_s;

	typedef struct packed {
		logic [1:0] range_check_start_delay;
		rvm_mode_e  monitor_operating_mode;
		logic       monitor_debounce_enable;
		logic       reset_on_fault_enable;
		logic [1:0] deviation_threshold_select;
	} rvm_control_s;

endpackage : rvm_pkg

/* rvm_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Range checks begin after zero, one, two or four measurements following enable.
// RULE2 - Mode 00 raises the event and shuts down an out-of-range regulator.
// RULE3 - Mode 01 raises the event after every finished channel 8, 9, 10 measurement.
// RULE4 - Mode 10 raises the event after the channel 10 slot; mode 11 reserved.
// RULE5 - Debounce bit requires two successive out-of-range results on a channel.
// RULE6 - Reset-on-fault drives system reset on detection, only while event mask is 1.
// RULE7 - Software should not make reset-on-fault part of the fused default setup.
// RULE8 - Threshold codes select about 25, 12.5, 6.25 or 3.125 percent windows.
// RULE9 - Second register enables linear 8, 7 and 3 watching at bits 7, 6, 2.
// RULE10 - Third register enables linear 11 at bit 2 and linear 9 at bit 0.
// RULE11 - Fourth register bits 7 to 2 enable the six buck converter watches.
// RULE12 - Read-only channel 8 last index: core1, core2, processor, linear 3, linear 11.
// RULE13 - Read-only channel 9 last index at bits 6:4: io, memory, peripheral buck.
// RULE14 - Read-only channel 10 last index sits at bits 2:0 of sixth register.
// RULE15 - Channel 10 codes: 010 linear 7, 011 linear 8, 100 linear 9.
// RULE16 - Out of range means deviation from target exceeds threshold in either direction.
module rvm_regs (
	input  wire logic                                   core_clk,
	input  wire logic                                   nrst,
	input  wire logic [8:0]                             reg_addr,
	input  wire logic                                   reg_wr_en,
	input  wire logic [7:0]                             reg_wr_data,
	input  wire logic                                   reg_rd_en,
	output logic      [7:0]                             reg_rd_data,
	input  wire rvm_pkg::rvm_meas_s [rvm_pkg::NUM_CH-1:0] meas,
	input  wire logic                                   out_of_range_event_mask,
	input  wire logic                                   interrupt_clear,
	output logic                                        out_of_range_event,
	output logic                                        interrupt_output_n,
	output logic                                        system_reset_output_n,
	output logic      [rvm_pkg::NUM_REG-1:0]            regulator_shutdown
);

	rvm_pkg::rvm_control_s       ctl_q;
	logic [7:0]                  en_la_q;
	logic [7:0]                  en_lb_q;
	logic [7:0]                  en_bk_q;
	logic [2:0]                  last_idx_q [rvm_pkg::NUM_CH];
	logic [2:0]                  meas_cnt_q [rvm_pkg::NUM_CH];
	logic [rvm_pkg::NUM_CH-1:0]  prev_out_q;
	logic [rvm_pkg::NUM_CH-1:0]  fault;
	logic [rvm_pkg::NUM_CH-1:0]  raw_out;
	logic [rvm_pkg::NUM_REG-1:0] fault_regs;
	logic [rvm_pkg::NUM_REG-1:0] watch_en;
	logic                        any_fault;
	logic                        event_now;

	// Regulator order: core1, core2, proc, io, mem, peri, lin3, lin7, lin8, lin9, lin11.
	assign watch_en = {en_lb_q[2], en_lb_q[0], en_la_q[7], en_la_q[6], en_la_q[2], // RULE9 RULE10
		en_bk_q[7], en_bk_q[6], en_bk_q[5], en_bk_q[4], en_bk_q[3], en_bk_q[2]}; // RULE11

	// Translates a channel's index code into a one-hot regulator vector.
	function automatic logic [rvm_pkg::NUM_REG-1:0] idx_to_reg(input int ch,
			input logic [2:0] idx);
		logic [rvm_pkg::NUM_REG-1:0] r;
		r = '0;
		case (ch)
			0: begin
				case (idx) // RULE12
					3'h1:    r[0]  = 1'b1;
					3'h2:    r[1]  = 1'b1;
					3'h3:    r[2]  = 1'b1;
					3'h4:    r[6]  = 1'b1;
					3'h6:    r[10] = 1'b1;
					default: r     = '0;
				endcase
			end
			1: begin
				case (idx) // RULE13
					3'h1:    r[3] = 1'b1;
					3'h2:    r[4] = 1'b1;
					3'h3:    r[5] = 1'b1;
					default: r    = '0;
				endcase
			end
			default: begin
				case (idx) // RULE15
					3'h2:    r[7] = 1'b1;
					3'h3:    r[8] = 1'b1;
					3'h4:    r[9] = 1'b1;
					default: r    = '0;
				endcase
			end
		endcase
		return r;
	endfunction : idx_to_reg

	// Number of earlier measurements its channel must see before a regulator's range is judged.
	function automatic logic [2:0] start_need(input logic [1:0] code);
		case (code) // RULE1
			2'b00:   return 3'h0;
			2'b01:   return 3'h1;
			2'b10:   return 3'h2;
			default: return 3'h4;
		endcase
	endfunction : start_need

	genvar g;
	generate
		for (g = 0; g < rvm_pkg::NUM_CH; g++) begin : g_ch
			logic [8:0]                  diff;
			logic [7:0]                  limit;
			logic [2:0]                  prior;
			logic [rvm_pkg::NUM_REG-1:0] sel;
			logic                        armed;

			assign sel   = idx_to_reg(g, meas[g].index);
			assign diff  = (meas[g].value >= meas[g].target) ?
				{1'b0, meas[g].value - meas[g].target} :
				{1'b0, meas[g].target - meas[g].value}; // RULE16
			assign limit = meas[g].target >> (rvm_pkg::THRES_BASE_SHIFT +
				{2'h0, ctl_q.deviation_threshold_select}); // RULE8
			assign prior = meas[g].fresh ? 3'h0 : meas_cnt_q[g];
			assign armed = prior >= start_need(ctl_q.range_check_start_delay); // RULE1
			assign raw_out[g] = meas[g].done && armed && ((sel & watch_en) != '0) &&
				(diff > {1'b0, limit}); // RULE16
			// A lone glitch is ignored when debouncing, at the cost of one slot of latency.
			assign fault[g] = raw_out[g] &&
				(!ctl_q.monitor_debounce_enable || prev_out_q[g]); // RULE5

			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					meas_cnt_q[g] <= 3'h0;
					prev_out_q[g] <= 1'b0;
				end else if (meas[g].done) begin
					meas_cnt_q[g] <= (prior == 3'h4) ? prior : prior + 3'h1; // RULE1
					prev_out_q[g] <= raw_out[g]; // RULE5
				end
			end

			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					last_idx_q[g] <= 3'h0;
				end else if (meas[g].done) begin
					last_idx_q[g] <= meas[g].index; // RULE12 RULE13 RULE14
				end
			end
		end
	endgenerate

	always_comb begin
		fault_regs = '0;
		for (int c = 0; c < rvm_pkg::NUM_CH; c++) begin
			if (fault[c]) begin
				fault_regs = fault_regs | idx_to_reg(c, meas[c].index);
			end
		end
	end

	assign any_fault = |fault;

	always_comb begin
		case (ctl_q.monitor_operating_mode)
			rvm_pkg::RVM_MODE_LOCKOUT: event_now = any_fault; // RULE2
			rvm_pkg::RVM_MODE_NORMAL:  event_now = |{meas[2].done, meas[1].done,
				meas[0].done}; // RULE3
			rvm_pkg::RVM_MODE_BURST:   event_now = meas[2].done; // RULE4
			default:                   event_now = 1'b0; // RULE4
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctl_q   <= rvm_pkg::RST_CONTROL;
			en_la_q <= rvm_pkg::RST_ENABLE_LA;
			en_lb_q <= rvm_pkg::RST_ENABLE_LB;
			en_bk_q <= rvm_pkg::RST_ENABLE_BK;
		end else if (reg_wr_en) begin
			case (reg_addr)
				rvm_pkg::ADDR_CONTROL:   ctl_q   <= reg_wr_data;
				rvm_pkg::ADDR_ENABLE_LA: en_la_q <= reg_wr_data & rvm_pkg::MASK_ENABLE_LA;
				rvm_pkg::ADDR_ENABLE_LB: en_lb_q <= reg_wr_data & rvm_pkg::MASK_ENABLE_LB;
				rvm_pkg::ADDR_ENABLE_BK: en_bk_q <= reg_wr_data & rvm_pkg::MASK_ENABLE_BK;
				default:                 ctl_q   <= ctl_q;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reg_rd_data <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				rvm_pkg::ADDR_CONTROL:   reg_rd_data <= ctl_q;
				rvm_pkg::ADDR_ENABLE_LA: reg_rd_data <= en_la_q;
				rvm_pkg::ADDR_ENABLE_LB: reg_rd_data <= en_lb_q;
				rvm_pkg::ADDR_ENABLE_BK: reg_rd_data <= en_bk_q;
				rvm_pkg::ADDR_LAST_89:   reg_rd_data <= {1'b0, last_idx_q[1], 1'b0,
					last_idx_q[0]}; // RULE12 RULE13
				rvm_pkg::ADDR_LAST_10:   reg_rd_data <= {5'h00, last_idx_q[2]}; // RULE14
				default:                 reg_rd_data <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			out_of_range_event <= 1'b0;
			interrupt_output_n <= 1'b1;
		end else begin
			out_of_range_event <= event_now; // RULE2 RULE3 RULE4
			// A new unmasked event wins over a clear arriving in the same cycle.
			if (event_now && !out_of_range_event_mask) begin
				interrupt_output_n <= 1'b0; // RULE2 RULE3 RULE4
			end else if (interrupt_clear) begin
				interrupt_output_n <= 1'b1;
			end
		end
	end

	// Shutdown and reset hold until device reset: a regulator that tripped must not
	// silently restart, which is why disabling its watch does not release it.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			regulator_shutdown <= '0;
		end else if (ctl_q.monitor_operating_mode == rvm_pkg::RVM_MODE_LOCKOUT) begin
			regulator_shutdown <= regulator_shutdown | fault_regs; // RULE2
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			system_reset_output_n <= 1'b1;
		end else if (any_fault && ctl_q.reset_on_fault_enable && out_of_range_event_mask) begin
			system_reset_output_n <= 1'b0; // RULE6
		end
	end

endmodule : rvm_regs

/* rvm_adc_model.sv */
`timescale 1ns/1ps
// Converter sequencer: hands one finished auto measurement to one monitor channel.
module rvm_adc_model (
	input  wire logic                                core_clk,
	output rvm_pkg::rvm_meas_s [rvm_pkg::NUM_CH-1:0] meas
);
	initial meas = '0;
	task automatic send(input int c, input logic f, input logic [2:0] x,
		input logic [7:0] v, input logic [7:0] t);
		@(posedge core_clk) #1;
		meas[c] = {1'b1, f, x, v, t};
		@(posedge core_clk) #1;
		// Result fields turn to junk once done drops, so stale values are never trusted.
		meas[c] = {1'b0, ~meas[c][17:0]};
	endtask : send
endmodule : rvm_adc_model

/* rvm_regs_assertions.sv */
`timescale 1ns/1ps
module rvm_regs_assertions (
	input wire logic                                core_clk,
	input wire logic                                nrst,
	input wire logic [8:0]                          reg_addr,
	input wire logic                                reg_wr_en,
	input wire logic [7:0]                          reg_wr_data,
	input wire logic                                reg_rd_en,
	input wire logic [7:0]                          reg_rd_data,
	input wire rvm_pkg::rvm_meas_s [rvm_pkg::NUM_CH-1:0] meas,
	input wire logic                                out_of_range_event_mask,
	input wire logic                                interrupt_clear,
	input wire logic                                out_of_range_event,
	input wire logic                                interrupt_output_n,
	input wire logic                                system_reset_output_n,
	input wire logic [rvm_pkg::NUM_REG-1:0]         regulator_shutdown
);
	logic [7:0] ctl_q;
	// Shadow of the control byte, so mode checks need no view inside the block.
	always_ff @(posedge core_clk) begin
		if (!nrst)
			ctl_q <= 8'h00;
		else if (reg_wr_en && reg_addr == rvm_pkg::ADDR_CONTROL)
			ctl_q <= reg_wr_data;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_event_cause: assert property (out_of_range_event |->
		$past(meas[0].done | meas[1].done | meas[2].done)) else $error("event without result");
	a_rsvd_mode: assert property ($past(ctl_q[5:4]) == 2'b11 |-> !out_of_range_event)
		else $error("event in reserved mode");
	a_irq_set: assert property (out_of_range_event && !$past(out_of_range_event_mask)
		|-> !interrupt_output_n) else $error("unmasked event left irq high");
	a_irq_release: assert property ($rose(interrupt_output_n)
		|-> $past(interrupt_clear) || !$past(nrst)) else $error("irq released by itself");
	a_rst_hold: assert property (!system_reset_output_n |=> !system_reset_output_n)
		else $error("system reset released");
	a_rst_cause: assert property ($fell(system_reset_output_n)
		|-> $past(out_of_range_event_mask) && $past(ctl_q[2])) else $error("reset not allowed");
	a_shut_mode: assert property ($past(ctl_q[5:4]) != 2'b00
		|-> $stable(regulator_shutdown) || !$past(nrst)) else $error("shutdown outside lockout");
	a_read_ctl: assert property (reg_rd_en && reg_addr == rvm_pkg::ADDR_CONTROL
		|=> reg_rd_data == $past(ctl_q)) else $error("control read wrong");
	a_rsvd_bits: assert property (reg_rd_en && reg_addr == rvm_pkg::ADDR_ENABLE_LA
		|=> (reg_rd_data & ~rvm_pkg::MASK_ENABLE_LA) == 8'h00) else $error("reserved bit set");
endmodule : rvm_regs_assertions

/* regulator_voltage_monitor_regs_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module regulator_voltage_monitor_regs_bench;
	logic                                 core_clk, nrst, reg_wr_en, reg_rd_en;
	logic                                 mask, interrupt_clear, out_of_range_event;
	logic                                 interrupt_output_n, system_reset_output_n;
	logic [8:0]                           reg_addr;
	logic [7:0]                           reg_wr_data, reg_rd_data;
	logic [10:0]                          regulator_shutdown;
	rvm_pkg::rvm_meas_s [2:0]             meas;
	int                                   miscompares = 0, checks_done = 0;
	rvm_regs DUT (.core_clk, .nrst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
		.reg_rd_data, .meas, .out_of_range_event_mask(mask), .interrupt_clear,
		.out_of_range_event, .interrupt_output_n, .system_reset_output_n, .regulator_shutdown);
	rvm_adc_model adc (.core_clk, .meas);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic rst(input int n);
		@(posedge core_clk) #1 nrst = 1'b0;
		repeat (n) @(posedge core_clk);
		#1 nrst = 1'b1;
	endtask : rst
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		{reg_addr, reg_wr_data, reg_wr_en} = {a, d, 1'b1};
		@(posedge core_clk) #1 reg_wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge core_clk) #1;
		{reg_addr, reg_rd_en} = {a, 1'b1};
		@(posedge core_clk) #1 reg_rd_en = 1'b0;
		`CHK(reg_rd_data, e)
	endtask : rd
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		{nrst, reg_wr_en, reg_rd_en, mask, interrupt_clear} = 5'h00;
		{reg_addr, reg_wr_data} = 17'h00000;
		rst(16);
		for (int i = 0; i < 12; i++) rd(9'h114 + 9'(i), 8'h00);
		wr(9'h115, 8'hFF); rd(9'h115, 8'hC4);
		wr(9'h116, 8'hFF); rd(9'h116, 8'h05);
		wr(9'h117, 8'hFF); rd(9'h117, 8'hFC);
		wr(9'h11E, 8'hFF); rd(9'h11E, 8'h00);
		wr(9'h114, 8'hF3); rd(9'h114, 8'hF3);
		adc.send(0, 0, 3'h1, 8'h00, 8'h80); `CHK(out_of_range_event, 1'b0)
		$display("registers test done");
		rst(2); wr(9'h117, 8'h04); adc.send(0, 1, 3'h1, 8'h40, 8'h80);
		`CHK(out_of_range_event, 1'b1)
		`CHK({regulator_shutdown, interrupt_output_n}, 12'h002)
		rd(9'h11E, 8'h01);
		@(posedge core_clk) #1 interrupt_clear = 1'b1;
		@(posedge core_clk) #1 interrupt_clear = 1'b0;
		`CHK(interrupt_output_n, 1'b1)
		wr(9'h114, 8'h03); wr(9'h116, 8'h01); adc.send(2, 0, 3'h4, 8'h84, 8'h80);
		`CHK(regulator_shutdown, 11'h001)
		adc.send(2, 0, 3'h4, 8'h7B, 8'h80); `CHK(regulator_shutdown, 11'h201)
		rd(9'h11F, 8'h04);
		$display("lockout test done");
		rst(2); wr(9'h114, 8'h40); wr(9'h117, 8'h08);
		adc.send(0, 1, 3'h2, 8'h00, 8'h80); `CHK(regulator_shutdown, 11'h000)
		adc.send(0, 0, 3'h2, 8'h00, 8'h80); `CHK(regulator_shutdown, 11'h002)
		rst(2); wr(9'h114, 8'h08); wr(9'h117, 8'h10);
		adc.send(0, 0, 3'h3, 8'h00, 8'h80); `CHK(regulator_shutdown, 11'h000)
		adc.send(0, 0, 3'h3, 8'h00, 8'h80); `CHK(regulator_shutdown, 11'h004)
		$display("delay test done");
		wr(9'h114, 8'h10); adc.send(1, 0, 3'h2, 8'h80, 8'h80);
		`CHK(out_of_range_event, 1'b1)
		rd(9'h11E, 8'h23);
		wr(9'h114, 8'h20); adc.send(1, 0, 3'h2, 8'h80, 8'h80);
		`CHK(out_of_range_event, 1'b0)
		adc.send(2, 0, 3'h2, 8'h80, 8'h80); `CHK(out_of_range_event, 1'b1)
		rd(9'h11F, 8'h02);
		$display("mode test done");
		rst(2); wr(9'h114, 8'h04); wr(9'h117, 8'h04);
		adc.send(0, 0, 3'h1, 8'h00, 8'h80);
		`CHK({system_reset_output_n, interrupt_output_n}, 2'b10)
		@(posedge core_clk) #1 mask = 1'b1;
		adc.send(0, 0, 3'h1, 8'h00, 8'h80);
		`CHK({system_reset_output_n, interrupt_output_n}, 2'b00)
		$display("reset test done");
		wrap_up();
	end
	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end
endmodule : regulator_voltage_monitor_regs_bench
bind rvm_regs rvm_regs_assertions chk (.core_clk, .nrst, .reg_addr, .reg_wr_en, .reg_wr_data,
	.reg_rd_en, .reg_rd_data, .meas, .out_of_range_event_mask, .interrupt_clear,
	.out_of_range_event, .interrupt_output_n, .system_reset_output_n, .regulator_shutdown);
